// >>> core/dcf_pkg.sv
// dcf_pkg: constants and types for the 18-bit flagged FIFO.
// assumes a single 100 MHz clock drives both the write and read sides.
package dcf_pkg;

   // data path geometry
   localparam int DATA_W = 18;
   localparam int DEPTH  = 8192;
   localparam int PTR_W  = 13;
   localparam int CNT_W  = 14;
   localparam int OFS_W  = 13;

   // capacity figures in word-count width
   localparam logic [13:0] DEPTH_CNT = 14'h2000;
   localparam logic [13:0] HALF_CNT  = 14'h1000;

   // default flag offsets chosen at master reset
   localparam logic [12:0] OFS_SHORT = 13'h007F;
   localparam logic [12:0] OFS_LONG  = 13'h03FF;

   // values after reset
   localparam logic [12:0] PTR_RST  = 13'h0000;
   localparam logic [13:0] CNT_RST  = 14'h0000;
   localparam logic [17:0] DATA_RST = 18'h00000;
   localparam logic [4:0]  PAD_ZERO = 5'h00;

   // empty indication after a retransmit
   localparam int CLK_PERIOD_NS = 10;
   localparam int RT_BLANK_NS   = 20;
   localparam int RT_BLANK_CYC  =
      (RT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] RT_BLANK_CNT = 2'(RT_BLANK_CYC);

   // timing mode, one-hot
   typedef enum logic [1:0] {
      DCF_MODE_STD = 2'b01,
      DCF_MODE_FT  = 2'b10
   } dcf_mode_type;

endpackage

// >>> core/dcf_offset_regs.sv
// dcf_offset_regs: almost-empty / almost-full offset registers.
// assumes control inputs are synchronous to ref_clk, active low.
`timescale 1ns/1ns
`default_nettype none

module dcf_offset_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // device control
   input  wire logic        master_reset_n,
   input  wire logic        partial_reset_n,
   input  wire logic        offset_access_n,
   input  wire logic        write_enable_n,
   input  wire logic        read_enable_n,
   input  wire logic        serial_load_enable_n,
   input  wire logic        serial_in,
   input  wire logic [12:0] parallel_in,
   // offsets and method
   output logic             serial_method,
   output logic [12:0]      empty_offset,
   output logic [12:0]      full_offset,
   output logic [12:0]      read_value
);

   logic [12:0] empty_ofs_r, empty_ofs_nxt;
   logic [12:0] full_ofs_r,  full_ofs_nxt;
   logic        serial_r,    serial_nxt;
   logic        wsel_r,      wsel_nxt;
   logic        rsel_r,      rsel_nxt;

   always_comb begin
      empty_ofs_nxt = empty_ofs_r;
      full_ofs_nxt  = full_ofs_r;
      serial_nxt    = serial_r;
      wsel_nxt      = wsel_r;
      rsel_nxt      = rsel_r;
      if (!master_reset_n) begin
         // load level picks default and method together
         serial_nxt    = offset_access_n;
         empty_ofs_nxt = offset_access_n ? dcf_pkg::OFS_LONG
                                         : dcf_pkg::OFS_SHORT;
         full_ofs_nxt  = empty_ofs_nxt;
         wsel_nxt      = 1'b0;
         rsel_nxt      = 1'b0;
      end else if (!partial_reset_n) begin
         // offsets and method survive; only access order restarts
         wsel_nxt = 1'b0;
         rsel_nxt = 1'b0;
      end else begin
         if (!offset_access_n && !write_enable_n && !serial_r) begin
            if (wsel_r) begin
               full_ofs_nxt = parallel_in;
            end else begin
               empty_ofs_nxt = parallel_in;
            end
            wsel_nxt = ~wsel_r;
         end
         if (!offset_access_n && !serial_load_enable_n && serial_r) begin
            // one bit per edge, lsb of empty offset first
            {full_ofs_nxt, empty_ofs_nxt} =
               {serial_in, full_ofs_r, empty_ofs_r[12:1]};
         end
         if (!offset_access_n && !read_enable_n) begin
            rsel_nxt = ~rsel_r;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         empty_ofs_r <= dcf_pkg::OFS_SHORT;
         full_ofs_r  <= dcf_pkg::OFS_SHORT;
         serial_r    <= 1'b0;
         wsel_r      <= 1'b0;
         rsel_r      <= 1'b0;
      end else begin
         empty_ofs_r <= empty_ofs_nxt;
         full_ofs_r  <= full_ofs_nxt;
         serial_r    <= serial_nxt;
         wsel_r      <= wsel_nxt;
         rsel_r      <= rsel_nxt;
      end
   end

   assign serial_method = serial_r;
   assign empty_offset  = empty_ofs_r;
   assign full_offset   = full_ofs_r;
   assign read_value    = rsel_r ? full_ofs_r : empty_ofs_r;

endmodule // dcf_offset_regs

`default_nettype wire

// >>> core/dcf_fifo.sv
// dcf_fifo: 8192 x 18 FIFO with standard / fall-through timing and
// programmable almost-empty / almost-full flags.
// assumes one clock for writer and reader; all inputs synchronous.
//
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - both resets zero pointers and output register
// - master reset latches mode, defaults, method
// - partial reset keeps mode, method, offsets
// - retransmit zeroes read pointer, shows empty briefly
// - retransmit spares write pointer, mode, offsets
// - mode select pin doubles as serial input
// - enabled write stores word or parallel offset
// - serial enable shifts one offset bit
// - enabled read presents word or offset
// - output enable controls data drive
// - load level picks 127 or 1023 default
// - load input redirects access to offsets
// - full flag, or input ready in fall-through
// - empty flag, or output ready in fall-through
// - almost-full low above capacity minus m
// - almost-empty low below offset n
// - half-full reports above half capacity
// - 127 pairs parallel, 1023 pairs serial
// - fall-through first word appears unrequested
// - depth 8192 words of 18 bits
module dcf_fifo (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // resets and mode
   input  wire logic        master_reset_n,
   input  wire logic        partial_reset_n,
   input  wire logic        retransmit_n,
   input  wire logic        fall_through_sel_serial_in,
   // write side
   input  wire logic        write_enable_n,
   input  wire logic        serial_load_enable_n,
   input  wire logic        offset_access_n,
   input  wire logic [17:0] write_data,
   // read side
   input  wire logic        read_enable_n,
   input  wire logic        output_enable_n,
   output logic [17:0]      read_data,
   output logic             read_data_oe,
   // status flags
   output logic             full_or_input_ready,
   output logic             empty_or_output_ready,
   output logic             almost_full_flag_n,
   output logic             almost_empty_flag_n,
   output logic             half_full_flag_n
);

   // storage, one 18-bit word per entry
   logic [17:0] mem_r [dcf_pkg::DEPTH];

   logic [12:0]          wr_ptr_r, wr_ptr_nxt;
   logic [12:0]          rd_ptr_r, rd_ptr_nxt;
   logic [13:0]          cnt_r,    cnt_nxt;
   logic [17:0]          out_r,    out_nxt;
   logic                 valid_r,  valid_nxt;
   logic [1:0]           blank_r,  blank_nxt;
   dcf_pkg::dcf_mode_type mode_r,  mode_nxt;

   logic        ft;
   logic        wr_mem;
   logic        rd_ofs;
   logic        pop;
   logic        retx;
   logic [13:0] total;
   logic        serial_method;
   logic [12:0] empty_ofs;
   logic [12:0] full_ofs;
   logic [12:0] ofs_value;

   dcf_offset_regs u_offsets (
      .ref_clk              (ref_clk),
      .sys_rst              (sys_rst),
      .master_reset_n       (master_reset_n),
      .partial_reset_n      (partial_reset_n),
      .offset_access_n      (offset_access_n),
      .write_enable_n       (write_enable_n),
      .read_enable_n        (read_enable_n),
      .serial_load_enable_n (serial_load_enable_n),
      .serial_in            (fall_through_sel_serial_in),
      .parallel_in          (write_data[12:0]),
      .serial_method        (serial_method),
      .empty_offset         (empty_ofs),
      .full_offset          (full_ofs),
      .read_value           (ofs_value)
   );

   assign ft   = (mode_r == dcf_pkg::DCF_MODE_FT);
   assign retx = !retransmit_n && master_reset_n && partial_reset_n;

   // single clock: counts and pointers share one domain, no crossing
   assign wr_mem = !write_enable_n && offset_access_n
                   && (cnt_r != dcf_pkg::DEPTH_CNT);
   assign rd_ofs = !read_enable_n && !offset_access_n;

   always_comb begin
      pop = 1'b0;
      if (!rd_ofs && cnt_r != dcf_pkg::CNT_RST && blank_r == 2'h0) begin
         if (ft) begin
            // refill the output when it is empty or being taken
            pop = !valid_r
                  || (!read_enable_n && offset_access_n);
         end else begin
            pop = !read_enable_n && offset_access_n;
         end
      end
   end

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      cnt_nxt    = cnt_r;
      out_nxt    = out_r;
      valid_nxt  = valid_r;
      blank_nxt  = (blank_r != 2'h0) ? blank_r - 2'h1 : blank_r;
      mode_nxt   = mode_r;
      if (!master_reset_n) begin
         mode_nxt   = fall_through_sel_serial_in ? dcf_pkg::DCF_MODE_FT
                                                 : dcf_pkg::DCF_MODE_STD;
         wr_ptr_nxt = dcf_pkg::PTR_RST;
         rd_ptr_nxt = dcf_pkg::PTR_RST;
         cnt_nxt    = dcf_pkg::CNT_RST;
         out_nxt    = dcf_pkg::DATA_RST;
         valid_nxt  = 1'b0;
         blank_nxt  = 2'h0;
      end else if (!partial_reset_n) begin
         // mode register untouched here
         wr_ptr_nxt = dcf_pkg::PTR_RST;
         rd_ptr_nxt = dcf_pkg::PTR_RST;
         cnt_nxt    = dcf_pkg::CNT_RST;
         out_nxt    = dcf_pkg::DATA_RST;
         valid_nxt  = 1'b0;
         blank_nxt  = 2'h0;
      end else begin
         if (wr_mem) begin
            wr_ptr_nxt = wr_ptr_r + 13'h0001;
         end
         if (retx) begin
            // words from location zero up to the write pointer
            rd_ptr_nxt = dcf_pkg::PTR_RST;
            cnt_nxt    = {1'b0, wr_ptr_r} + {13'h0000, wr_mem};
            valid_nxt  = 1'b0;
            blank_nxt  = dcf_pkg::RT_BLANK_CNT;
         end else begin
            if (rd_ofs) begin
               out_nxt   = {dcf_pkg::PAD_ZERO, ofs_value};
               valid_nxt = 1'b0;
            end else if (pop) begin
               out_nxt    = mem_r[rd_ptr_r];
               rd_ptr_nxt = rd_ptr_r + 13'h0001;
               valid_nxt  = 1'b1;
            end else if (ft && !read_enable_n && offset_access_n) begin
               valid_nxt = 1'b0;
            end
            cnt_nxt = cnt_r + {13'h0000, wr_mem} - {13'h0000, pop};
         end
      end
   end

   // storage keeps no reset; only pointers define contents
   always_ff @(posedge ref_clk) begin
      if (wr_mem && master_reset_n && partial_reset_n) begin
         mem_r[wr_ptr_r] <= write_data;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= dcf_pkg::PTR_RST;
         rd_ptr_r <= dcf_pkg::PTR_RST;
         cnt_r    <= dcf_pkg::CNT_RST;
         out_r    <= dcf_pkg::DATA_RST;
         valid_r  <= 1'b0;
         blank_r  <= 2'h0;
         mode_r   <= dcf_pkg::DCF_MODE_STD;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r    <= cnt_nxt;
         out_r    <= out_nxt;
         valid_r  <= valid_nxt;
         blank_r  <= blank_nxt;
         mode_r   <= mode_nxt;
      end
   end

   // word in the output register counts as stored in fall-through
   assign total = cnt_r + {13'h0000, ft && valid_r};

   assign read_data    = out_r;
   assign read_data_oe = !output_enable_n;

   // every flag below is asserted low
   assign full_or_input_ready = ft ? (cnt_r == dcf_pkg::DEPTH_CNT)
                                   : (cnt_r != dcf_pkg::DEPTH_CNT);
   assign empty_or_output_ready =
      ft ? !valid_r
         : (cnt_r != dcf_pkg::CNT_RST && blank_r == 2'h0);
   assign almost_full_flag_n =
      !(total > dcf_pkg::DEPTH_CNT - {1'b0, full_ofs});
   assign almost_empty_flag_n = !(total < {1'b0, empty_ofs});
   assign half_full_flag_n    = !(total > dcf_pkg::HALF_CNT);

   both_resets_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (!master_reset_n || !partial_reset_n)
      |=> (wr_ptr_r == 13'h0000 && rd_ptr_r == 13'h0000
           && read_data == 18'h00000 && cnt_r == 14'h0000))
      else $error("reset did not clear pointers and output");

   mode_latch_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !master_reset_n |=> (ft == $past(fall_through_sel_serial_in)))
      else $error("timing mode not latched at master reset");

   mode_keep_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      master_reset_n |=> $stable(mode_r))
      else $error("timing mode changed outside master reset");

   retx_ptr_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (retx && write_enable_n)
      |=> (rd_ptr_r == 13'h0000 && $stable(wr_ptr_r)
           && $stable(mode_r) && $stable(full_ofs)))
      else $error("retransmit disturbed more than the read pointer");

   retx_blank_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (retx && !ft) |=> (!empty_or_output_ready)[*2])
      else $error("empty not shown after retransmit");

   write_count_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (wr_mem && !pop && !retx && master_reset_n && partial_reset_n)
      |=> (cnt_r == $past(cnt_r) + 14'h0001))
      else $error("accepted write not counted");

   std_full_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (!ft && cnt_r == dcf_pkg::DEPTH_CNT)
      |-> (!full_or_input_ready && !half_full_flag_n))
      else $error("full memory not flagged");

   almost_full_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (total > 14'h2000 - {1'b0, full_ofs}) |-> !almost_full_flag_n)
      else $error("almost-full flag missing");

   almost_empty_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (total >= {1'b0, empty_ofs}) |-> almost_empty_flag_n)
      else $error("almost-empty flag false");

   ft_first_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (ft && !valid_r && cnt_r == 14'h0000 && wr_mem && blank_r == 2'h0
       && master_reset_n && partial_reset_n && retransmit_n
       && read_enable_n)
      ##1 (master_reset_n && partial_reset_n && retransmit_n
           && read_enable_n)
      |=> !empty_or_output_ready)
      else $error("first word did not fall through");

   retx_ready_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (retx && ft) |=> (empty_or_output_ready && blank_r != 2'h0))
      else $error("output ready not dropped after retransmit");

   prs_keep_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (master_reset_n && !partial_reset_n)
      |=> ($stable(empty_ofs) && $stable(full_ofs)
           && $stable(serial_method)))
      else $error("partial reset disturbed offsets or method");

   serial_shift_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (master_reset_n && partial_reset_n && serial_method
       && !offset_access_n && !serial_load_enable_n)
      |=> (full_ofs[12] == $past(fall_through_sel_serial_in)
           && empty_ofs[12] == $past(full_ofs[0])))
      else $error("serial offset bit not shifted in");

   std_read_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (!ft && !read_enable_n && offset_access_n && cnt_r != 14'h0000
       && blank_r == 2'h0 && !retx && master_reset_n && partial_reset_n)
      |=> (rd_ptr_r == $past(rd_ptr_r) + 13'h0001
           && read_data == $past(mem_r[rd_ptr_r])))
      else $error("read did not present next word");

   ofs_read_a: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_ofs && !retx && master_reset_n && partial_reset_n)
      |=> (read_data == {5'h00, $past(ofs_value)}
           && rd_ptr_r == $past(rd_ptr_r)))
      else $error("offset read touched the data path");

endmodule // dcf_fifo

`default_nettype wire

// >>> test/dcf_far_end.sv
// dcf_far_end: writer and reader facing the FIFO data ports.
// assumes ref_clk is the FIFO clock; each task returns at a negedge.
`timescale 1ns/1ns
`default_nettype none

module dcf_far_end (
   // clock
   input  wire logic        ref_clk,
   // writer and reader
   output var logic         write_enable_n,
   output var logic         read_enable_n,
   output var logic [17:0]  write_data
);
   initial begin
      write_enable_n = 1'h1;
      read_enable_n  = 1'h1;
      write_data     = 18'h00000;
   end

   // n words base, base+1, ... on back-to-back edges
   task automatic push(input int n, input logic [17:0] base);
      @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         write_enable_n <= 1'h0;
         write_data     <= base + 18'(i);
         @(posedge ref_clk);
      end
      write_enable_n <= 1'h1;
      // released bus must not keep looking like the last word
      write_data     <= ~write_data;
      @(negedge ref_clk);
   endtask

   task automatic pop();
      @(posedge ref_clk);
      read_enable_n <= 1'h0;
      @(posedge ref_clk);
      read_enable_n <= 1'h1;
      @(negedge ref_clk);
   endtask
endmodule // dcf_far_end

`default_nettype wire

// >>> test/tb_top.sv
// tb_top: self-checking bench for the 18-bit flagged FIFO.
// assumes one 100 MHz clock; far end model drives the data strobes.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
   logic        ref_clk;
   logic        sys_rst;
   logic        master_reset_n;
   logic        partial_reset_n;
   logic        retransmit_n;
   logic        fall_through_sel_serial_in;
   logic        serial_load_enable_n;
   logic        offset_access_n;
   logic        output_enable_n;
   logic        write_enable_n;
   logic        read_enable_n;
   logic [17:0] write_data;
   logic [17:0] read_data;
   logic        read_data_oe;
   logic        full_or_input_ready;
   logic        empty_or_output_ready;
   logic        almost_full_flag_n;
   logic        almost_empty_flag_n;
   logic        half_full_flag_n;
   int          n_errors;
   int          comparisons;

   dcf_far_end far_u (
      .ref_clk        (ref_clk),
      .write_enable_n (write_enable_n),
      .read_enable_n  (read_enable_n),
      .write_data     (write_data)
   );

   dcf_fifo dut_u (
      .ref_clk                    (ref_clk),
      .sys_rst                    (sys_rst),
      .master_reset_n             (master_reset_n),
      .partial_reset_n            (partial_reset_n),
      .retransmit_n               (retransmit_n),
      .fall_through_sel_serial_in (fall_through_sel_serial_in),
      .write_enable_n             (write_enable_n),
      .serial_load_enable_n       (serial_load_enable_n),
      .offset_access_n            (offset_access_n),
      .write_data                 (write_data),
      .read_enable_n              (read_enable_n),
      .output_enable_n            (output_enable_n),
      .read_data                  (read_data),
      .read_data_oe               (read_data_oe),
      .full_or_input_ready        (full_or_input_ready),
      .empty_or_output_ready      (empty_or_output_ready),
      .almost_full_flag_n         (almost_full_flag_n),
      .almost_empty_flag_n        (almost_empty_flag_n),
      .half_full_flag_n           (half_full_flag_n)
   );

   always #5 ref_clk = ~ref_clk;

   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // order: full, empty, almost full, almost empty, half full
   task automatic flags(input logic [4:0] e);
      `CHK("flags", e, {full_or_input_ready, empty_or_output_ready,
         almost_full_flag_n, almost_empty_flag_n, half_full_flag_n})
   endtask

   task automatic popchk(input logic [17:0] e);
      far_u.pop();
      `CHK("read_data", e, read_data)
   endtask

   task automatic mreset(input logic ft, input logic oa);
      @(posedge ref_clk);
      master_reset_n <= 1'h0;
      fall_through_sel_serial_in <= ft;
      offset_access_n <= oa;
      @(posedge ref_clk);
      master_reset_n <= 1'h1;
      fall_through_sel_serial_in <= 1'h0;
      offset_access_n <= 1'h1;
      @(negedge ref_clk);
   endtask

   task automatic preset();
      @(posedge ref_clk);
      partial_reset_n <= 1'h0;
      @(posedge ref_clk);
      partial_reset_n <= 1'h1;
      @(negedge ref_clk);
      `CHK("read_data", 18'h00000, read_data)
      flags(5'h15);
   endtask

   // offset readback: empty offset first, then full offset
   task automatic offs(input logic [12:0] e, input logic [12:0] f);
      @(posedge ref_clk);
      offset_access_n <= 1'h0;
      popchk({5'h00, e});
      popchk({5'h00, f});
      @(posedge ref_clk);
      offset_access_n <= 1'h1;
      @(negedge ref_clk);
   endtask

   task automatic t_reset();
      mreset(1'h0, 1'h0);
      flags(5'h15);
      @(posedge ref_clk);
      output_enable_n <= 1'h0;
      @(negedge ref_clk);
      `CHK("oe", 1'h1, read_data_oe)
      @(posedge ref_clk);
      output_enable_n <= 1'h1;
      @(negedge ref_clk);
      `CHK("oe", 1'h0, read_data_oe)
   endtask

   task automatic t_std_rw();
      far_u.push(3, 18'h3FFF0);
      flags(5'h1D);
      popchk(18'h3FFF0);
      popchk(18'h3FFF1);
      popchk(18'h3FFF2);
      flags(5'h15);
      popchk(18'h3FFF2);
   endtask

   task automatic t_par_ofs();
      offs(13'h007F, 13'h007F);
      @(posedge ref_clk);
      offset_access_n <= 1'h0;
      far_u.push(1, 18'h00003);
      far_u.push(1, 18'h00004);
      @(posedge ref_clk);
      offset_access_n <= 1'h1;
      @(negedge ref_clk);
      offs(13'h0003, 13'h0004);
      preset();
      offs(13'h0003, 13'h0004);
   endtask

   // thresholds with empty offset 3 and full offset 4
   task automatic t_fill();
      far_u.push(2, 18'h00100);
      flags(5'h1D);
      far_u.push(1, 18'h00102);
      flags(5'h1F);
      far_u.push(4093, 18'h00000);
      flags(5'h1F);
      far_u.push(1, 18'h00000);
      flags(5'h1E);
      far_u.push(4091, 18'h00000);
      flags(5'h1E);
      far_u.push(1, 18'h00000);
      flags(5'h1A);
      far_u.push(3, 18'h00000);
      flags(5'h0A);
      far_u.push(1, 18'h00000);
      flags(5'h0A);
      popchk(18'h00100);
   endtask

   task automatic t_retx();
      preset();
      far_u.push(2, 18'h2AAAA);
      popchk(18'h2AAAA);
      popchk(18'h2AAAB);
      @(posedge ref_clk);
      retransmit_n <= 1'h0;
      @(posedge ref_clk);
      retransmit_n <= 1'h1;
      @(negedge ref_clk);
      `CHK("blank", 1'h0, empty_or_output_ready)
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("blank", 1'h1, empty_or_output_ready)
      popchk(18'h2AAAA);
      offs(13'h0003, 13'h0004);
   endtask

   task automatic t_ser_ft();
      logic [25:0] v;
      v = {13'h0009, 13'h0005};
      mreset(1'h1, 1'h1);
      `CHK("read_data", 18'h00000, read_data)
      flags(5'h0D);
      offs(13'h03FF, 13'h03FF);
      @(posedge ref_clk);
      offset_access_n <= 1'h0;
      serial_load_enable_n <= 1'h0;
      // empty offset lsb goes in first, full offset msb last
      for (int i = 0; i < 26; i++) begin
         fall_through_sel_serial_in <= v[i];
         @(posedge ref_clk);
      end
      offset_access_n <= 1'h1;
      serial_load_enable_n <= 1'h1;
      @(negedge ref_clk);
      offs(13'h0005, 13'h0009);
      far_u.push(1, 18'h12345);
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("read_data", 18'h12345, read_data)
      flags(5'h05);
      far_u.pop();
      flags(5'h0D);
      // fall-through retransmit drops ready, then refills word zero
      @(posedge ref_clk);
      retransmit_n <= 1'h0;
      @(posedge ref_clk);
      retransmit_n <= 1'h1;
      @(negedge ref_clk);
      `CHK("ready", 1'h1, empty_or_output_ready)
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("ready", 1'h1, empty_or_output_ready)
      @(posedge ref_clk);
      @(negedge ref_clk);
      flags(5'h05);
   endtask

   initial begin
      ref_clk = 1'h0;
      sys_rst = 1'h1;
      master_reset_n = 1'h1;
      partial_reset_n = 1'h1;
      retransmit_n = 1'h1;
      fall_through_sel_serial_in = 1'h0;
      serial_load_enable_n = 1'h1;
      offset_access_n = 1'h1;
      output_enable_n = 1'h1;
      n_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'h0;
      @(negedge ref_clk);
      t_reset();
      t_std_rw();
      t_par_ofs();
      t_fill();
      t_retx();
      t_ser_ft();
      results();
   end

   // whole run is near 8,300 cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      results();
   end
endmodule // tb_top

`default_nettype wire
